// ---- pkg/rhpd_params.svh ----
// Offsets, field positions, reset values for the root hub port descriptor
`ifndef RHPD_PARAMS_SVH
`define RHPD_PARAMS_SVH
`define RHPD_ADDR_W 8
`define RHPD_DESC_OFF 8'h00
`define RHPD_PORTCNT_OFF 8'h04
`define RHPD_PPM_LSB 17
`define RHPD_PPM_MSB 19
`define RHPD_FDF_LSB 1
`define RHPD_FDF_MSB 3
`define RHPD_PORT_N 3
`define RHPD_DESC_RST 32'h0000_0000
`define RHPD_DESC_WMASK 32'h000e_000e
`define RHPD_PORT_COUNT 8'h03
`define RHPD_RESP_OKAY 2'h0
`define RHPD_RESP_SLVERR 2'h2
`endif

// ---- pkg/rhpd_pkg.sv ----
// Types for the root hub port descriptor register block
package rhpd_pkg;
   typedef logic [31:0] rhpd_word_type;
   typedef logic [1:0] rhpd_resp_type;
   typedef enum logic [1:0] {
      RHPD_W_IDLE = 2'b00,
      RHPD_W_RESP = 2'b01
   } rhpd_wstate_type;
endpackage

// ---- rtl/rhpd_port_bit.sv ----
// One per-port setting bit with byte-lane gated software write
`timescale 1ns/1ps
module rhpd_port_bit (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic wr_val,
   output logic q
);
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= 1'b0;
      end else if (wr_en) begin
         q <= wr_val;
      end
   end
endmodule

// ---- rtl/rhpd_rd_mux.sv ----
// Registered read data and response for the register slave
`timescale 1ns/1ps
`include "rhpd_params.svh"
module rhpd_rd_mux (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [`RHPD_ADDR_W-1:0] addr,
   input wire logic [31:0] desc,
   output logic [31:0] rdata,
   output logic [1:0] resp
);
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
         resp <= `RHPD_RESP_OKAY;
      end else if (load) begin
         if (addr == `RHPD_DESC_OFF) begin
            rdata <= desc;
            resp <= `RHPD_RESP_OKAY;
         end else if (addr == `RHPD_PORTCNT_OFF) begin
            rdata <= {24'h00_0000, `RHPD_PORT_COUNT};
            resp <= `RHPD_RESP_OKAY;
         end else begin
            rdata <= 32'h0000_0000;
            resp <= `RHPD_RESP_SLVERR;
         end
      end
   end
endmodule

// ---- rtl/rhpd_top.sv ----
// Root hub port descriptor register with AXI4-Lite slave
//
// Overview of operation
// - Mask bits 31..20 reserved, read zero
// - Bit 19 power select for port 3
// - Bit 18 power select for port 2
// - Bit 17 power select for port 1
// - Mask bit 16 reserved, reads zero
// - Flag bits 15..4 reserved, read zero
// - Bit 3 fixed-device flag port 3
// - Bit 2 fixed-device flag port 2
// - Bit 1 fixed-device flag port 1
// - Flag bit 0 reserved, reads zero
// - Power mask writable and read back
// - No pin switches port power
// - Port count reads three always
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rhpd_params.svh"
module rhpd_top
   import rhpd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [`RHPD_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output rhpd_pkg::rhpd_resp_type S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [`RHPD_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output rhpd_pkg::rhpd_word_type S_AXI_RDATA,
   output rhpd_pkg::rhpd_resp_type S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [2:0] PORT_POWER_SELECT_MASK,
   output logic [2:0] FIXED_DEVICE_FLAGS
);
   import rhpd_pkg::*;

   // ------------------------------------------------------------
   // Write channel capture
   // ------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [`RHPD_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   rhpd_wstate_type wstate_r;
   logic do_write;
   logic aw_take;
   logic w_take;

   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take = S_AXI_WVALID && S_AXI_WREADY;
   assign do_write = aw_held_r && w_held_r && (wstate_r == RHPD_W_IDLE);

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         S_AXI_AWREADY <= 1'b0;
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else begin
         S_AXI_AWREADY <= !aw_held_r && !aw_take && !S_AXI_AWREADY;
         if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         S_AXI_WREADY <= 1'b0;
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         S_AXI_WREADY <= !w_held_r && !w_take && !S_AXI_WREADY;
         if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         wstate_r <= RHPD_W_IDLE;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RHPD_RESP_OKAY;
      end else begin
         case (wstate_r)
            RHPD_W_IDLE: begin
               if (do_write) begin
                  wstate_r <= RHPD_W_RESP;
                  S_AXI_BVALID <= 1'b1;
                  if (awaddr_r == `RHPD_DESC_OFF ||
                      awaddr_r == `RHPD_PORTCNT_OFF) begin
                     S_AXI_BRESP <= `RHPD_RESP_OKAY;
                  end else begin
                     S_AXI_BRESP <= `RHPD_RESP_SLVERR;
                  end
               end
            end
            RHPD_W_RESP: begin
               if (S_AXI_BREADY) begin
                  wstate_r <= RHPD_W_IDLE;
                  S_AXI_BVALID <= 1'b0;
               end
            end
            default: begin
               wstate_r <= RHPD_W_IDLE;
               S_AXI_BVALID <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Descriptor fields
   // ------------------------------------------------------------
   logic desc_sel;
   logic [31:0] wr_masked;
   logic [2:0] ppm_q;
   logic [2:0] fdf_q;
   logic [31:0] desc_word;

   assign desc_sel = do_write && (awaddr_r == `RHPD_DESC_OFF);
   assign wr_masked = wdata_r & `RHPD_DESC_WMASK;

   genvar gi;
   generate
      for (gi = 0; gi < `RHPD_PORT_N; gi = gi + 1) begin : g_port
         rhpd_port_bit u_ppm (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .wr_en(desc_sel && wstrb_r[2]),
            .wr_val(wr_masked[`RHPD_PPM_LSB + gi]),
            .q(ppm_q[gi])
         );
         rhpd_port_bit u_fdf (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .wr_en(desc_sel && wstrb_r[0]),
            .wr_val(wr_masked[`RHPD_FDF_LSB + gi]),
            .q(fdf_q[gi])
         );
      end
   endgenerate

   always_comb begin
      desc_word = `RHPD_DESC_RST;
      desc_word[`RHPD_PPM_MSB:`RHPD_PPM_LSB] = ppm_q;
      desc_word[`RHPD_FDF_MSB:`RHPD_FDF_LSB] = fdf_q;
   end

   // Status copies only, no power switch
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         PORT_POWER_SELECT_MASK <= 3'h0;
         FIXED_DEVICE_FLAGS <= 3'h0;
      end else begin
         PORT_POWER_SELECT_MASK <= ppm_q;
         FIXED_DEVICE_FLAGS <= fdf_q;
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic ar_take;
   assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !ar_take && !S_AXI_ARREADY;
         if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // Port count answered in read mux
   rhpd_rd_mux u_rd (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .load(ar_take),
      .addr(S_AXI_ARADDR),
      .desc(desc_word),
      .rdata(S_AXI_RDATA),
      .resp(S_AXI_RRESP)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_resv_zero;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == `RHPD_DESC_OFF
      |-> (S_AXI_RDATA & ~`RHPD_DESC_WMASK) == 32'h0;
   endproperty
   a_resv_zero: assert property (p_resv_zero)
      else $error("Reserved descriptor bits read nonzero");

   property p_write_lands;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[2] |=> ppm_q == $past(wdata_r[19:17]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("Power mask write not stored");

   property p_flag_lands;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[0] |=> fdf_q == $past(wdata_r[3:1]);
   endproperty
   a_flag_lands: assert property (p_flag_lands)
      else $error("Fixed flag write not stored");

   property p_hold;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      !desc_sel |=> $stable(ppm_q) && $stable(fdf_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Descriptor changed without write");

   property p_port_count;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ar_take && S_AXI_ARADDR == `RHPD_PORTCNT_OFF
      |=> S_AXI_RDATA == 32'h3 && S_AXI_RVALID;
   endproperty
   a_port_count: assert property (p_port_count)
      else $error("Port count not three");

   property p_out_follow;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      1'b1 |=> PORT_POWER_SELECT_MASK == $past(ppm_q);
   endproperty
   a_out_follow: assert property (p_out_follow)
      else $error("Mask status output lags");

   property p_bresp;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      do_write |=> S_AXI_BVALID;
   endproperty
   a_bresp: assert property (p_bresp)
      else $error("Write response missing");

   property p_read_desc;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ar_take && S_AXI_ARADDR == `RHPD_DESC_OFF
      |=> S_AXI_RDATA[19:17] == $past(ppm_q)
          && S_AXI_RDATA[3:1] == $past(fdf_q);
   endproperty
   a_read_desc: assert property (p_read_desc)
      else $error("Descriptor read mismatch");

   property p_flag_follow;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      1'b1 |=> FIXED_DEVICE_FLAGS == $past(fdf_q);
   endproperty
   a_flag_follow: assert property (p_flag_follow)
      else $error("Flag status output lags");

   property p_port3_mask;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[2]
      |=> desc_word[`RHPD_PPM_MSB] == $past(wdata_r[`RHPD_PPM_MSB]);
   endproperty
   a_port3_mask: assert property (p_port3_mask)
      else $error("Port 3 power select not stored");

   property p_port1_mask;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[2]
      |=> desc_word[`RHPD_PPM_LSB] == $past(wdata_r[`RHPD_PPM_LSB]);
   endproperty
   a_port1_mask: assert property (p_port1_mask)
      else $error("Port 1 power select not stored");

   property p_port2_flag;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[0]
      |=> desc_word[`RHPD_FDF_LSB + 1] == $past(wdata_r[`RHPD_FDF_LSB + 1]);
   endproperty
   a_port2_flag: assert property (p_port2_flag)
      else $error("Port 2 fixed flag not stored");

   property p_port1_flag;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && wstrb_r[0]
      |=> desc_word[`RHPD_FDF_LSB] == $past(wdata_r[`RHPD_FDF_LSB]);
   endproperty
   a_port1_flag: assert property (p_port1_flag)
      else $error("Port 1 fixed flag not stored");

   property p_mask_lane;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && !wstrb_r[2] |=> $stable(ppm_q);
   endproperty
   a_mask_lane: assert property (p_mask_lane)
      else $error("Power mask changed with lane off");

   property p_flag_lane;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      desc_sel && !wstrb_r[0] |=> $stable(fdf_q);
   endproperty
   a_flag_lane: assert property (p_flag_lane)
      else $error("Fixed flags changed with lane off");

   property p_count_write;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      do_write && awaddr_r == `RHPD_PORTCNT_OFF
      |=> S_AXI_BVALID && S_AXI_BRESP == `RHPD_RESP_OKAY;
   endproperty
   a_count_write: assert property (p_count_write)
      else $error("Port count write not answered okay");

   property p_bad_write;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      do_write && awaddr_r != `RHPD_DESC_OFF
      |=> $stable(ppm_q) && $stable(fdf_q);
   endproperty
   a_bad_write: assert property (p_bad_write)
      else $error("Descriptor changed by other address");

   property p_desc_okay;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      do_write && awaddr_r == `RHPD_DESC_OFF
      |=> S_AXI_BVALID && S_AXI_BRESP == `RHPD_RESP_OKAY;
   endproperty
   a_desc_okay: assert property (p_desc_okay)
      else $error("Descriptor write not answered okay");

   c_write: cover property (@(posedge SYS_CLK) desc_sel);
   c_read: cover property (@(posedge SYS_CLK) ar_take);
   c_bad: cover property (@(posedge SYS_CLK)
      S_AXI_BVALID && S_AXI_BRESP != 2'h0);
   c_part_strobe: cover property (@(posedge SYS_CLK)
      desc_sel && wstrb_r != 4'hf);
   c_count_read: cover property (@(posedge SYS_CLK)
      ar_take && S_AXI_ARADDR == `RHPD_PORTCNT_OFF);
endmodule

// ---- test/test_rhpd_top.sv ----
// Self-checking bench for the root hub port descriptor register
`timescale 1ns/1ps
`include "rhpd_params.svh"
module test_rhpd_top;
   import rhpd_pkg::*;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [`RHPD_ADDR_W-1:0] S_AXI_AWADDR = '0;
   logic [`RHPD_ADDR_W-1:0] S_AXI_ARADDR = '0;
   logic S_AXI_AWVALID = 1'b0;
   logic S_AXI_WVALID = 1'b0;
   logic S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0;
   logic S_AXI_RREADY = 1'b0;
   logic [31:0] S_AXI_WDATA = 32'h0000_0000;
   logic [3:0] S_AXI_WSTRB = 4'h0;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_ARREADY, S_AXI_RVALID;
   rhpd_resp_type S_AXI_BRESP, S_AXI_RRESP;
   rhpd_word_type S_AXI_RDATA;
   logic [2:0] PORT_POWER_SELECT_MASK, FIXED_DEVICE_FLAGS;
   int miscompares = 0;
   int checks_done = 0;
   rhpd_word_type rd;
   rhpd_resp_type rs;

   always #12.5 SYS_CLK = ~SYS_CLK;

   rhpd_top dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
      .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
      .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
      .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
      .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
      .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
      .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
      .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
      .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
      .S_AXI_RREADY(S_AXI_RREADY),
      .PORT_POWER_SELECT_MASK(PORT_POWER_SELECT_MASK),
      .FIXED_DEVICE_FLAGS(FIXED_DEVICE_FLAGS));

   // ---------------------------------------------
   // Report and compare
   // ---------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp_word(input string nm, input rhpd_word_type e,
                           input rhpd_word_type g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_resp(input string nm, input rhpd_resp_type e,
                           input rhpd_resp_type g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic cmp_pins(input logic [2:0] em, input logic [2:0] ef);
      @(posedge SYS_CLK);
      @(posedge SYS_CLK);
      checks_done++;
      if (PORT_POWER_SELECT_MASK !== em || FIXED_DEVICE_FLAGS !== ef) begin
         miscompares++;
         $display("MISMATCH pins expected %b %b seen %b %b", em, ef,
                  PORT_POWER_SELECT_MASK, FIXED_DEVICE_FLAGS);
      end
   endtask

   // ---------------------------------------------
   // Bus cycles
   // ---------------------------------------------
   task automatic wr(input logic [7:0] a, input rhpd_word_type d,
                     input logic [3:0] s, input rhpd_resp_type er);
      bit done;
      done = 0;
      @(posedge SYS_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge SYS_CLK);
         if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
         if (S_AXI_BVALID === 1'b1) begin
            done = 1;
            S_AXI_BREADY <= 1'b0;
            cmp_resp("bresp", er, S_AXI_BRESP);
         end
      end
      if (!done) begin
         miscompares++;
         results();
      end
   endtask

   task automatic rdw(input logic [7:0] a, input rhpd_word_type ed,
                      input rhpd_resp_type er);
      bit done;
      done = 0;
      @(posedge SYS_CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge SYS_CLK);
         if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
         if (S_AXI_RVALID === 1'b1) begin
            done = 1;
            S_AXI_RREADY <= 1'b0;
            cmp_resp("rresp", er, S_AXI_RRESP);
            cmp_word("rdata", ed, S_AXI_RDATA);
         end
      end
      if (!done) begin
         miscompares++;
         results();
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset_values();
      rdw(8'h00, 32'h0000_0000, 2'h0);
      rdw(8'h04, 32'h0000_0003, 2'h0);
      cmp_pins(3'h0, 3'h0);
      $display("test reset values done");
   endtask

   task automatic test_all_ones();
      wr(8'h00, 32'hffff_ffff, 4'hf, 2'h0);
      rdw(8'h00, 32'h000e_000e, 2'h0);
      cmp_pins(3'h7, 3'h7);
      $display("test all ones done");
   endtask

   task automatic test_each_port();
      rhpd_word_type d;
      for (int i = 0; i < 3; i++) begin
         d = (32'h1 << (17 + i)) | (32'h1 << (3 - i));
         wr(8'h00, d, 4'hf, 2'h0);
         rdw(8'h00, d, 2'h0);
         cmp_pins(3'h1 << i, 3'h4 >> i);
      end
      $display("test each port done");
   endtask

   task automatic test_strobes();
      wr(8'h00, 32'h000e_000e, 4'hf, 2'h0);
      wr(8'h00, 32'h0000_0000, 4'hb, 2'h0);
      rdw(8'h00, 32'h000e_0000, 2'h0);
      wr(8'h00, 32'h0000_0000, 4'h4, 2'h0);
      rdw(8'h00, 32'h0000_0000, 2'h0);
      $display("test strobes done");
   endtask

   task automatic test_refusals();
      wr(8'h00, 32'h0004_0004, 4'hf, 2'h0);
      wr(8'h04, 32'hffff_ffff, 4'hf, 2'h0);
      rdw(8'h04, 32'h0000_0003, 2'h0);
      wr(8'h08, 32'hffff_ffff, 4'hf, 2'h2);
      rdw(8'h00, 32'h0004_0004, 2'h0);
      rdw(8'h08, 32'h0000_0000, 2'h2);
      $display("test refusals done");
   endtask

   task automatic test_mid_reset();
      wr(8'h00, 32'h000e_000e, 4'hf, 2'h0);
      @(posedge SYS_CLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      rdw(8'h00, 32'h0000_0000, 2'h0);
      cmp_pins(3'h0, 3'h0);
      $display("test mid reset done");
   endtask

   initial begin
      repeat (16) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      test_reset_values();
      test_all_ones();
      test_each_port();
      test_strobes();
      test_refusals();
      test_mid_reset();
      results();
   end
endmodule
